//--- leu_load_unit.sv
// load extract and merge unit: address, alignment, lanes, extension
`timescale 1ns/1ps
module leu_load_unit
   import leu_pkg::*;
(
   input wire logic clk,                     // 25 MHz clock
   input wire logic rst,                     // synchronous reset, high
   input wire logic req_valid,               // instruction offered
   input wire logic [5:0] req_opcode,        // primary opcode
   input wire logic [4:0] req_base_field,    // base / source field
   input wire logic [4:0] req_dest_reg_field, // destination field
   input wire logic [15:0] req_imm,          // offset or immediate
   input wire logic [63:0] req_base_value,   // base register contents
   input wire logic [63:0] req_dest_value,   // destination old contents
   input wire logic cpu_byte_order_flag,     // 1 = big-endian cpu
   input wire logic memory_byte_order_flag,  // 1 = big-endian memory
   input wire logic mem_rsp_valid,           // read data returned
   input wire logic [127:0] mem_rdata,       // returned quadword
   input wire logic mem_tlb_refill,          // translation miss
   input wire logic mem_tlb_invalid,         // translation invalid
   output logic req_ready,                   // may take an instruction
   output logic mem_req,                     // read request pulse
   output logic [31:0] mem_addr,             // address with lane offset
   output logic [2:0] access_byte_count_code, // bytes minus one
   output logic wb_valid,                    // register write pulse
   output logic [4:0] wb_dest,               // register to write
   output logic [63:0] wb_data,              // value to write
   output logic exc_valid,                   // exception pulse
   output leu_exc_t exc_code,                // exception cause
   output logic [31:0] exc_vaddr             // faulting address
);
   leu_state_t state_q;
   leu_op_t op_d, op_q;
   logic [31:0] ea_d, ea_q;
   logic misalign_d, accept, is_mem_op, issue;
   logic be_q;
   logic [4:0] dest_q;
   logic [63:0] old_q, old_d;
   logic [3:0] half_idx, word_idx, left_idx;
   logic [1:0] left_cnt;
   logic [15:0] half_f;
   logic [31:0] word_f, left_w, merged;
   logic [63:0] result;
   logic rsp_fault;
   logic req_ready_q, mem_req_q, wb_valid_q, exc_valid_q;
   logic [31:0] mem_addr_q, exc_vaddr_q;
   logic [2:0] len_q;
   logic [4:0] wb_dest_q;
   logic [63:0] wb_data_q;
   leu_exc_t exc_code_q;
   logic [3:0] ofs_d;
   logic [2:0] len_d;

   always_comb begin
      op_d = OP_NONE;
      case (req_opcode)
         OPC_LOAD_HALF_SIGNED: op_d = OP_HALF_S;
         OPC_LOAD_HALF_UNSIGNED: op_d = OP_HALF_U;
         OPC_LOAD_WORD_SIGNED: op_d = OP_WORD_S;
         OPC_LOAD_WORD_LEFT_PART: op_d = OP_WORD_LEFT;
         OPC_LOAD_UPPER_IMMEDIATE: begin
            if (req_base_field == LUI_SRC_FIELD) begin
               op_d = OP_UPPER_IMM;
            end
         end
         default: op_d = OP_NONE;
      endcase
   end

   // only the low word of the base takes part
   assign ea_d = req_base_value[31:0] + {{16{req_imm[15]}}, req_imm};

   always_comb begin
      misalign_d = 1'b0;
      case (op_d)
         OP_HALF_S, OP_HALF_U: misalign_d = ea_d[0];
         OP_WORD_S: misalign_d = (ea_d[1:0] != 2'b00);
         default: misalign_d = 1'b0;
      endcase
   end

   assign accept = req_valid && req_ready_q;
   assign is_mem_op = (op_d == OP_HALF_S) || (op_d == OP_HALF_U) ||
                      (op_d == OP_WORD_S) || (op_d == OP_WORD_LEFT);
   assign issue = accept && is_mem_op && !misalign_d;

   // register file may not hold the last result yet, so bypass it
   assign old_d = (wb_valid_q && wb_dest_q == req_dest_reg_field) ?
                  wb_data_q : req_dest_value;

   always_comb begin
      ofs_d = ea_d[3:0];
      len_d = LEN_HALF;
      case (op_d)
         OP_HALF_S, OP_HALF_U: begin
            ofs_d = ea_d[3:0] ^ {{3{cpu_byte_order_flag}}, 1'b0};
            len_d = LEN_HALF;
         end
         OP_WORD_S: begin
            ofs_d = ea_d[3:0] ^ {{2{cpu_byte_order_flag}}, 2'b00};
            len_d = LEN_WORD;
         end
         OP_WORD_LEFT: begin
            ofs_d = ea_d[3:0] ^
                    {4{cpu_byte_order_flag ^ memory_byte_order_flag}};
            ofs_d[1:0] = memory_byte_order_flag ? ofs_d[1:0] : 2'b00;
            len_d = cpu_byte_order_flag ?
                    {1'b0, LEN_LEFT_BE_BASE[1:0] - ea_d[1:0]} :
                    {1'b0, ea_d[1:0]};
         end
         default: ofs_d = ea_d[3:0];
      endcase
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         state_q <= ST_IDLE;
         req_ready_q <= 1'b0;
      end else begin
         case (state_q)
            ST_IDLE: begin
               req_ready_q <= !issue;
               if (issue) begin
                  state_q <= ST_WAIT;
               end
            end
            ST_WAIT: begin
               req_ready_q <= mem_rsp_valid;
               if (mem_rsp_valid) begin
                  state_q <= ST_IDLE;
               end
            end
            default: begin
               state_q <= ST_IDLE;
               req_ready_q <= 1'b1;
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         op_q <= OP_NONE;
         ea_q <= 32'h0000_0000;
         be_q <= 1'b0;
         dest_q <= 5'h00;
         old_q <= 64'h0;
      end else if (accept) begin
         op_q <= op_d;
         ea_q <= ea_d;
         be_q <= cpu_byte_order_flag;
         dest_q <= req_dest_reg_field;
         old_q <= old_d;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         mem_req_q <= 1'b0;
         mem_addr_q <= 32'h0000_0000;
         len_q <= 3'h0;
      end else begin
         mem_req_q <= issue;
         if (issue) begin
            mem_addr_q <= {ea_d[31:4], ofs_d};
            len_q <= len_d;
         end
      end
   end

   // lane indexes use the endian flag latched with the request
   assign half_idx = ea_q[3:0] ^ {{3{be_q}}, 1'b0};
   assign word_idx = ea_q[3:0] ^ {{2{be_q}}, 2'b00};
   assign left_cnt = ea_q[1:0] ^ {2{be_q}};
   assign left_idx = {ea_q[3:2] ^ {2{be_q}}, 2'b00};

   leu_lane_pick #(.W(HALF_W)) u_half_pick (
      .quad(mem_rdata),
      .idx(half_idx),
      .field(half_f)
   );

   leu_lane_pick #(.W(WORD_W)) u_word_pick (
      .quad(mem_rdata),
      .idx(word_idx),
      .field(word_f)
   );

   leu_lane_pick #(.W(WORD_W)) u_left_pick (
      .quad(mem_rdata),
      .idx(left_idx),
      .field(left_w)
   );

   // memory bytes fill from the top down to the aligned word edge
   always_comb begin
      case (left_cnt)
         2'd0: merged = {left_w[7:0], old_q[23:0]};
         2'd1: merged = {left_w[15:0], old_q[15:0]};
         2'd2: merged = {left_w[23:0], old_q[7:0]};
         default: merged = left_w;
      endcase
   end

   always_comb begin
      case (op_q)
         OP_HALF_S: result = {{48{half_f[15]}}, half_f};
         OP_HALF_U: result = {48'h0, half_f};
         OP_WORD_S: result = {{32{word_f[31]}}, word_f};
         OP_WORD_LEFT: result = {{32{merged[31]}}, merged};
         default: result = 64'h0;
      endcase
   end

   assign rsp_fault = mem_tlb_refill || mem_tlb_invalid;

   always_ff @(posedge clk) begin
      if (rst) begin
         wb_valid_q <= 1'b0;
         wb_dest_q <= 5'h00;
         wb_data_q <= 64'h0;
      end else begin
         wb_valid_q <= 1'b0;
         if (accept && op_d == OP_UPPER_IMM) begin
            wb_valid_q <= 1'b1;
            wb_dest_q <= req_dest_reg_field;
            wb_data_q <= {{32{req_imm[15]}}, req_imm, LUI_LOW_ZERO};
         end else if (state_q == ST_WAIT && mem_rsp_valid && !rsp_fault) begin
            wb_valid_q <= 1'b1;
            wb_dest_q <= dest_q;
            wb_data_q <= result;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         exc_valid_q <= 1'b0;
         exc_code_q <= EXC_NONE;
         exc_vaddr_q <= 32'h0000_0000;
      end else begin
         exc_valid_q <= 1'b0;
         if (accept && is_mem_op && misalign_d) begin
            exc_valid_q <= 1'b1;
            exc_code_q <= EXC_ADDR_ERROR;
            exc_vaddr_q <= ea_d;
         end else if (state_q == ST_WAIT && mem_rsp_valid && rsp_fault) begin
            exc_valid_q <= 1'b1;
            exc_code_q <= mem_tlb_refill ? EXC_TLB_REFILL : EXC_TLB_INVALID;
            exc_vaddr_q <= ea_q;
         end
      end
   end

   assign req_ready = req_ready_q;
   assign mem_req = mem_req_q;
   assign mem_addr = mem_addr_q;
   assign access_byte_count_code = len_q;
   assign wb_valid = wb_valid_q;
   assign wb_dest = wb_dest_q;
   assign wb_data = wb_data_q;
   assign exc_valid = exc_valid_q;
   assign exc_code = exc_code_q;
   assign exc_vaddr = exc_vaddr_q;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   AST_EA_FORM: assert property (accept && is_mem_op |=> ea_q ==
      $past(req_base_value[31:0]) + {{16{$past(req_imm[15])}},
      $past(req_imm)})
      else $error("effective address wrong");
   AST_HALF_ALIGN: assert property (accept &&
      (op_d == OP_HALF_S || op_d == OP_HALF_U) && ea_d[0]
      |=> exc_valid && exc_code == EXC_ADDR_ERROR && !mem_req)
      else $error("misaligned halfword not trapped");
   AST_WORD_ALIGN: assert property (accept && op_d == OP_WORD_S &&
      ea_d[1:0] != 2'b00 |=> exc_valid && exc_code == EXC_ADDR_ERROR)
      else $error("misaligned word not trapped");
   AST_LEFT_NO_ALIGN: assert property (accept &&
      op_d == OP_WORD_LEFT |=> mem_req && !exc_valid)
      else $error("left part load trapped or not issued");
   AST_UPPER_IMM: assert property (accept && op_d == OP_UPPER_IMM
      |=> wb_valid && !mem_req && wb_data[15:0] == 16'h0000 &&
      wb_data[31:16] == $past(req_imm) && wb_data[63:32] == {32{wb_data[31]}})
      else $error("upper immediate result wrong");
   AST_HALF_U_ZERO: assert property (state_q == ST_WAIT && mem_rsp_valid
      && !rsp_fault && op_q == OP_HALF_U |=> wb_valid &&
      wb_data[63:16] == 48'h0)
      else $error("unsigned halfword not zero-extended");
   AST_WORD_SIGN: assert property (state_q == ST_WAIT && mem_rsp_valid
      && !rsp_fault && op_q == OP_WORD_S |=> wb_valid &&
      wb_data[63:32] == {32{wb_data[31]}})
      else $error("word not sign-extended");
   AST_LEFT_SIGN: assert property (wb_valid && $past(op_q) == OP_WORD_LEFT
      && $past(state_q) == ST_WAIT |-> wb_data[63:32] == {32{wb_data[31]}})
      else $error("left merge upper half wrong");
   AST_FAULT_NO_WB: assert property (state_q == ST_WAIT && mem_rsp_valid
      && rsp_fault |=> exc_valid && !wb_valid)
      else $error("faulting load still wrote register");
   AST_FORWARD: assert property (accept && wb_valid_q &&
      wb_dest_q == req_dest_reg_field |=> old_q == $past(wb_data_q))
      else $error("result not forwarded to merge");
   AST_ONE_OUTSTANDING: assert property (mem_req |-> !req_ready ##1
      !mem_req)
      else $error("second read issued while waiting");

   COV_HALF: cover property (wb_valid && $past(op_q) == OP_HALF_S);
   COV_LEFT_FWD: cover property (accept && op_d == OP_WORD_LEFT &&
      wb_valid_q && wb_dest_q == req_dest_reg_field);
   COV_TLB: cover property (exc_valid && exc_code == EXC_TLB_REFILL);
   COV_BE_WORD: cover property (issue && op_d == OP_WORD_S &&
      cpu_byte_order_flag);
endmodule // leu_load_unit

//--- leu_pkg.sv
// shared constants and types for the load extract and merge unit
package leu_pkg;
   localparam logic [5:0] OPC_LOAD_HALF_SIGNED = 6'h21;
   localparam logic [5:0] OPC_LOAD_HALF_UNSIGNED = 6'h25;
   localparam logic [5:0] OPC_LOAD_UPPER_IMMEDIATE = 6'h0F;
   localparam logic [5:0] OPC_LOAD_WORD_SIGNED = 6'h23;
   localparam logic [5:0] OPC_LOAD_WORD_LEFT_PART = 6'h22;
   localparam logic [4:0] LUI_SRC_FIELD = 5'h00;

   // access_byte_count_code values (bytes minus one), plus the top lane offset OFS_BE_MEM_TOP
   localparam logic [2:0] LEN_HALF = 3'h1;
   localparam logic [2:0] LEN_WORD = 3'h3;
   localparam logic [3:0] LEN_LEFT_BE_BASE = 4'h3;
   localparam logic [3:0] OFS_BE_MEM_TOP = 4'hF;

   localparam int QUAD_W = 128;
   localparam int HALF_W = 16;
   localparam int WORD_W = 32;
   localparam logic [15:0] LUI_LOW_ZERO = 16'h0000;

   typedef enum logic [1:0] {
      EXC_NONE,
      EXC_ADDR_ERROR,
      EXC_TLB_REFILL,
      EXC_TLB_INVALID
   } leu_exc_t;

   typedef enum logic [2:0] {
      OP_NONE,
      OP_HALF_S,
      OP_HALF_U,
      OP_UPPER_IMM,
      OP_WORD_S,
      OP_WORD_LEFT
   } leu_op_t;

   typedef enum logic {
      ST_IDLE,
      ST_WAIT
   } leu_state_t;
endpackage

//--- leu_lane_pick.sv
// picks a byte-aligned field out of a memory quadword
`timescale 1ns/1ps
module leu_lane_pick #(
   parameter int W = 16
) (
   input wire logic [127:0] quad, // memory quadword
   input wire logic [3:0] idx,    // starting byte lane
   output logic [W-1:0] field     // selected bytes, lowest lane in lsb
);
   logic [127:0] shifted;

   assign shifted = quad >> {idx, 3'b000};
   assign field = shifted[W-1:0];
endmodule // leu_lane_pick

//--- leu_mem_model.sv
// memory read port model: returns quadwords, stalls, reports faults
`timescale 1ns/1ps
module leu_mem_model (
   input wire logic clk, // clock
   input wire logic rst, // synchronous reset
   input wire logic mem_req, // read request pulse
   input wire logic [31:0] mem_addr, // read address
   input wire logic [1:0] fault, // bit0 refill, bit1 invalid
   input wire logic [3:0] delay, // wait cycles before reply
   output logic mem_rsp_valid, // reply pulse
   output logic [127:0] mem_rdata, // quadword
   output logic mem_tlb_refill, // refill fault
   output logic mem_tlb_invalid // invalid fault
);
   logic [127:0] image [0:15];
   logic busy_q;
   logic [3:0] cnt_q;
   logic [3:0] row_q;
   logic [1:0] flt_q;

   always_ff @(posedge clk) begin
      mem_rsp_valid <= 1'b0;
      // idle lines wander so stale data never passes for a reply
      mem_rdata <= ~mem_rdata;
      mem_tlb_refill <= ~mem_tlb_refill;
      mem_tlb_invalid <= ~mem_tlb_invalid;
      if (rst) begin
         busy_q <= 1'b0;
         mem_rdata <= 128'h0;
         mem_tlb_refill <= 1'b0;
         mem_tlb_invalid <= 1'b0;
      end else begin
         if (mem_req) begin
            row_q <= mem_addr[7:4];
            flt_q <= fault;
         end
         if (mem_req ? delay == 4'h0 : busy_q && cnt_q == 4'h0) begin
            mem_rsp_valid <= 1'b1;
            mem_rdata <= image[mem_req ? mem_addr[7:4] : row_q];
            mem_tlb_refill <= mem_req ? fault[0] : flt_q[0];
            mem_tlb_invalid <= mem_req ? fault[1] : flt_q[1];
            busy_q <= 1'b0;
         end else if (mem_req) begin
            busy_q <= 1'b1;
            cnt_q <= delay - 4'h1;
         end else if (busy_q) begin
            cnt_q <= cnt_q - 4'h1;
         end
      end
   end
endmodule // leu_mem_model

//--- tb_load_extract_and_merge_unit.sv
// self-checking bench for the load extract and merge unit
`timescale 1ns/1ps
module tb_load_extract_and_merge_unit;
   import leu_pkg::*;
   typedef struct packed {
      logic is_exc;
      logic [4:0] dest;
      logic [63:0] data;
      leu_exc_t code;
      logic [31:0] vaddr;
   } leu_exp_t;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic req_valid = 1'b0;
   logic [5:0] req_opcode = 6'h00;
   logic [4:0] req_base_field = 5'h00;
   logic [4:0] req_dest_reg_field = 5'h00;
   logic [15:0] req_imm = 16'h0000;
   logic [63:0] req_base_value = 64'h0;
   logic [63:0] req_dest_value = 64'h0;
   logic cpu_byte_order_flag = 1'b0;
   logic memory_byte_order_flag = 1'b0;
   logic [1:0] fault = 2'h0;
   logic [3:0] delay = 4'h0;
   logic mem_rsp_valid, mem_tlb_refill, mem_tlb_invalid;
   logic [127:0] mem_rdata;
   logic req_ready, mem_req, wb_valid, exc_valid;
   logic [31:0] mem_addr, exc_vaddr;
   logic [2:0] access_byte_count_code;
   logic [4:0] wb_dest;
   logic [63:0] wb_data;
   leu_exc_t exc_code;
   int n_errors = 0;
   int n_compared = 0;
   integer seed = 60589;
   leu_exp_t eq[$];
   logic [34:0] mq[$];
   leu_exp_t got_e;
   logic [34:0] got_m;
   logic [63:0] last_data;

   always #20 clk = ~clk;

   leu_load_unit u_dut (.clk(clk), .rst(rst), .req_valid(req_valid),
      .req_opcode(req_opcode), .req_base_field(req_base_field),
      .req_dest_reg_field(req_dest_reg_field), .req_imm(req_imm),
      .req_base_value(req_base_value), .req_dest_value(req_dest_value),
      .cpu_byte_order_flag(cpu_byte_order_flag),
      .memory_byte_order_flag(memory_byte_order_flag),
      .mem_rsp_valid(mem_rsp_valid), .mem_rdata(mem_rdata),
      .mem_tlb_refill(mem_tlb_refill), .mem_tlb_invalid(mem_tlb_invalid),
      .req_ready(req_ready), .mem_req(mem_req), .mem_addr(mem_addr),
      .access_byte_count_code(access_byte_count_code),
      .wb_valid(wb_valid), .wb_dest(wb_dest), .wb_data(wb_data),
      .exc_valid(exc_valid), .exc_code(exc_code), .exc_vaddr(exc_vaddr));

   leu_mem_model u_mem (.clk(clk), .rst(rst), .mem_req(mem_req),
      .mem_addr(mem_addr), .fault(fault), .delay(delay),
      .mem_rsp_valid(mem_rsp_valid), .mem_rdata(mem_rdata),
      .mem_tlb_refill(mem_tlb_refill), .mem_tlb_invalid(mem_tlb_invalid));

   task automatic check(input logic [63:0] seen, input logic [63:0] exp,
         input string what);
      n_compared++;
      if (seen !== exp) begin
         n_errors++;
         $display("[FAIL] %0t %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask

   task automatic tally_and_finish;
      $display("compared %0d mismatches %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   // fwd: previous write lands in the accept cycle, so it is the old value
   task automatic issue(input logic [5:0] opc, input logic [4:0] dst,
         input logic [15:0] imm, input logic [63:0] base,
         input logic [63:0] old, input logic fwd, input logic b,
         input logic m);
      logic [31:0] ea;
      logic [127:0] q;
      logic [3:0] ln;
      logic [1:0] c;
      logic [31:0] t;
      logic [63:0] oe;
      logic rd;
      logic push;
      leu_exp_t e;
      int k;
      req_valid <= 1'b1;
      req_opcode <= opc;
      req_dest_reg_field <= dst;
      req_imm <= imm;
      req_base_value <= base;
      req_dest_value <= old;
      cpu_byte_order_flag <= b;
      memory_byte_order_flag <= m;
      req_base_field <= base[36:32];
      k = 0;
      do begin
         @(posedge clk);
         k++;
      end while (req_ready !== 1'b1 && k < 60);
      oe = fwd ? last_data : old;
      ea = {{16{imm[15]}}, imm} + base[31:0];
      q = u_mem.image[ea[7:4]];
      e = '0;
      e.dest = dst;
      e.vaddr = ea;
      rd = 1'b1;
      push = 1'b1;
      case (opc)
         OPC_LOAD_UPPER_IMMEDIATE: begin
            rd = 1'b0;
            push = base[36:32] == LUI_SRC_FIELD;
            e.data = {{32{imm[15]}}, imm, LUI_LOW_ZERO};
         end
         OPC_LOAD_HALF_SIGNED, OPC_LOAD_HALF_UNSIGNED: begin
            e.is_exc = ea[0];
            ln = ea[3:0] ^ {b, b, b, 1'b0};
            q = q >> (8 * ln);
            e.data = {{48{q[15] & (opc == OPC_LOAD_HALF_SIGNED)}},
               q[15:0]};
            if (!e.is_exc) mq.push_back({ea[31:4], ln, LEN_HALF});
         end
         OPC_LOAD_WORD_SIGNED: begin
            e.is_exc = ea[1:0] != 2'b00;
            ln = ea[3:0] ^ {b, b, 2'b00};
            q = q >> (8 * ln);
            e.data = {{32{q[31]}}, q[31:0]};
            if (!e.is_exc) mq.push_back({ea[31:4], ln, LEN_WORD});
         end
         OPC_LOAD_WORD_LEFT_PART: begin
            c = ea[1:0] ^ {b, b};
            ln = (b ^ m) ? OFS_BE_MEM_TOP - ea[3:0] : ea[3:0];
            if (!m) ln[1:0] = 2'b00;
            mq.push_back({ea[31:4], ln, 1'b0,
               b ? 2'h3 - ea[1:0] : ea[1:0]});
            q = q >> (32 * (ea[3:2] ^ {b, b}));
            t = (q[31:0] << (8 * (3 - c))) |
               (oe[31:0] & ((32'h1 << (8 * (3 - c))) - 32'h1));
            e.data = {{32{t[31]}}, t};
         end
         default: push = 1'b0;
      endcase
      if (e.is_exc) e.code = EXC_ADDR_ERROR;
      else if (rd && fault != 2'h0) begin
         e.is_exc = 1'b1;
         e.code = fault[0] ? EXC_TLB_REFILL : EXC_TLB_INVALID;
      end
      if (push) eq.push_back(e);
      if (push && !e.is_exc) last_data = e.data;
   endtask

   task automatic wait_done(input string name);
      int k;
      req_valid <= 1'b0;
      k = 0;
      do begin
         @(posedge clk);
         k++;
      end while (eq.size() + mq.size() != 0 && k < 60);
      check({63'h0, k < 60}, 64'h1, "completion");
      repeat (2) @(posedge clk);
      $display("test %s done", name);
   endtask

   task automatic sweep(input logic [5:0] opc, input string name);
      logic [31:0] r;
      logic [63:0] base;
      for (int i = 0; i < 64; i++) begin
         r = $random(seed);
         base = {$random(seed), $random(seed)};
         base[3:0] = i[3:0] - r[3:0];
         delay <= {2'b00, r[1:0]};
         issue(opc, i[4:0], r[31:16], base, {$random(seed), r}, 1'b0,
            i[4], i[5]);
      end
      wait_done(name);
   endtask

   always @(posedge clk) begin
      if (!rst && mem_req === 1'b1) begin
         if (mq.size() == 0) check(64'h1, 64'h0, "unexpected read");
         else begin
            got_m = mq.pop_front();
            check({29'h0, mem_addr, access_byte_count_code},
               {29'h0, got_m}, "read address");
         end
      end
      if (!rst && (wb_valid === 1'b1 || exc_valid === 1'b1)) begin
         if (eq.size() == 0) check(64'h1, 64'h0, "unexpected result");
         else begin
            got_e = eq.pop_front();
            check({62'h0, exc_valid, wb_valid},
               {62'h0, got_e.is_exc, !got_e.is_exc}, "kind");
            if (got_e.is_exc) check({30'h0, exc_code, exc_vaddr},
               {30'h0, got_e.code, got_e.vaddr}, "exception");
            else begin
               check(wb_data, got_e.data, "write data");
               check({59'h0, wb_dest}, {59'h0, got_e.dest}, "dest");
            end
         end
      end
   end

   initial begin
      repeat (20000) @(posedge clk);
      n_errors++;
      $display("[FAIL] %0t watchdog expired", $time);
      tally_and_finish;
   end

   initial begin
      for (int i = 0; i < 16; i++) begin
         u_mem.image[i] = {$random(seed), $random(seed), $random(seed),
            $random(seed)};
      end
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      for (int i = 0; i < 6; i++) begin
         issue(OPC_LOAD_UPPER_IMMEDIATE, i[4:0], i == 0 ? 16'h8000
            : 16'h7FFF - i[15:0], 64'h0, 64'h0, 1'b0, 1'b0, 1'b0);
      end
      wait_done("upper immediate");
      sweep(OPC_LOAD_HALF_SIGNED, "half signed");
      sweep(OPC_LOAD_HALF_UNSIGNED, "half unsigned");
      sweep(OPC_LOAD_WORD_SIGNED, "word signed");
      sweep(OPC_LOAD_WORD_LEFT_PART, "left part");
      for (int f = 1; f < 4; f++) begin
         fault <= f[1:0];
         delay <= f[3:0];
         issue(OPC_LOAD_WORD_SIGNED, 5'h03, 16'h0010, 64'h100, 64'h0,
            1'b0, 1'b0, 1'b0);
         issue(OPC_LOAD_HALF_SIGNED, 5'h04, 16'h0011, 64'h100, 64'h0,
            1'b0, 1'b0, 1'b0);
         wait_done("faults");
      end
      fault <= 2'h0;
      issue(OPC_LOAD_UPPER_IMMEDIATE, 5'h07, 16'hC3A5, 64'h0, 64'h0,
         1'b0, 1'b0, 1'b0);
      issue(OPC_LOAD_WORD_LEFT_PART, 5'h07, 16'h0000, 64'h20,
         64'h5555_5555_5555_5555, 1'b1, 1'b0, 1'b0);
      issue(OPC_LOAD_HALF_UNSIGNED, 5'h09, 16'h0002, 64'h40, 64'h0,
         1'b0, 1'b1, 1'b0);
      issue(OPC_LOAD_WORD_LEFT_PART, 5'h09, 16'h0001, 64'h30,
         64'hAAAA_AAAA_AAAA_AAAA, 1'b1, 1'b1, 1'b1);
      wait_done("bypass");
      issue(6'h3F, 5'h0A, 16'h0004, 64'h0, 64'h0, 1'b0, 1'b0, 1'b0);
      issue(OPC_LOAD_UPPER_IMMEDIATE, 5'h0B, 16'h1234, 64'h10_0000_0000,
         64'h0, 1'b0, 1'b0, 1'b0);
      wait_done("unknown opcode");
      tally_and_finish;
   end
endmodule // tb_load_extract_and_merge_unit
